// *** include/omc_pkg.sv ***
package omc_pkg;

   localparam int OMC_NCH = 4;
   localparam int OMC_FIRST_CH = 4;
   localparam int OMC_LVL_W = 2;

   // Register indices; byte address is four times the index
   localparam logic [5:0] OMC_IDX_MUTE_LEVEL = 6'h15;
   localparam logic [5:0] OMC_IDX_AUTO_DISABLE = 6'h16;
   localparam logic [5:0] OMC_IDX_STATUS = 6'h17;
   localparam logic [5:0] OMC_IDX_FORMAT = 6'h18;

   localparam logic [1:0] OMC_LVL_BYPASS = 2'h0;
   localparam logic [1:0] OMC_LVL_LOW_P = 2'h1;
   localparam logic [1:0] OMC_LVL_HIGH_N = 2'h2;
   localparam logic [1:0] OMC_LVL_RAIL = 2'h3;

   localparam logic [7:0] OMC_MUTE_LEVEL_RST = 8'h55;
   localparam logic [3:0] OMC_AUTO_DISABLE_RST = 4'hF;
   localparam logic [3:0] OMC_FORMAT_RST = 4'hF;

   // Field positions inside the 8-bit registers
   localparam int OMC_AUTO_LSB = 4;
   localparam int OMC_STAT_MUTED_LSB = 4;
   localparam int OMC_STAT_VALID_BIT = 0;
   localparam int OMC_FORMAT_LSB = 0;

   typedef enum {
      OMC_BUS_IDLE,
      OMC_BUS_ACK
   } omc_bus_state_t;

endpackage

// *** src/omc_drive_decode.sv ***
`timescale 1ns/1ps
module omc_drive_decode
   import omc_pkg::*;
(
   input wire logic [1:0] level_code,
   input wire logic differential,
   input wire logic muted,
   input wire logic run_clk,
   output logic pos_level,
   output logic neg_level,
   output logic to_vcm,
   output logic pos_to_rail
);

   always_comb begin
      pos_level = run_clk;
      neg_level = differential ? ~run_clk : run_clk;
      to_vcm = 1'b0;
      pos_to_rail = 1'b0;
      // Code only shapes the muted output
      if (muted) begin
         if (differential) begin
            case (level_code)
               OMC_LVL_BYPASS: begin
               end
               OMC_LVL_LOW_P: begin
                  pos_level = 1'b0;
                  neg_level = 1'b0;
                  to_vcm = 1'b1;
               end
               OMC_LVL_HIGH_N: begin
                  pos_level = 1'b1;
                  neg_level = 1'b0;
               end
               OMC_LVL_RAIL: begin
                  pos_level = 1'b1;
                  neg_level = 1'b0;
                  pos_to_rail = 1'b1;
               end
               default: begin
               end
            endcase
         end else begin
            case (level_code)
               OMC_LVL_BYPASS: begin
               end
               OMC_LVL_LOW_P: begin
                  neg_level = 1'b0;
               end
               OMC_LVL_HIGH_N: begin
                  pos_level = 1'b0;
               end
               OMC_LVL_RAIL: begin
                  pos_level = 1'b0;
                  neg_level = 1'b0;
               end
               default: begin
               end
            endcase
         end
      end
   end

endmodule // omc_drive_decode

// *** src/omc_mute_level.sv ***
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
module omc_mute_level
   import omc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic clk_src_valid,
   input wire logic [3:0] chan_run_clk,
   output logic [3:0] chan_pos,
   output logic [3:0] chan_neg,
   output logic [3:0] chan_vcm,
   output logic [3:0] chan_rail,
   output logic [3:0] chan_muted
);

   ////////////////////////////////////////////////////////////////////////////
   // Address decode

   function automatic logic hit(input logic [7:0] adr, input logic [5:0] idx);
      hit = (adr[7:2] == idx);
   endfunction

   omc_bus_state_t bus_q;
   omc_bus_state_t bus_d;
   logic [7:0] upper_channel_mute_level_q;
   logic [7:0] upper_channel_mute_level_d;
   logic [3:0] auto_disable_q;
   logic [3:0] auto_disable_d;
   logic [3:0] format_q;
   logic [3:0] format_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;

   wire req = wb_cyc_i && wb_stb_i;
   wire take = req && (bus_q == OMC_BUS_IDLE);
   // Writes land on the acknowledged edge, the one the master sees
   wire commit = req && (bus_q == OMC_BUS_ACK);
   wire wr_lane0 = commit && wb_we_i && wb_sel_i[0];
   wire hit_level = hit(wb_adr_i, OMC_IDX_MUTE_LEVEL);
   wire hit_auto = hit(wb_adr_i, OMC_IDX_AUTO_DISABLE);
   wire hit_status = hit(wb_adr_i, OMC_IDX_STATUS);
   wire hit_format = hit(wb_adr_i, OMC_IDX_FORMAT);

   ////////////////////////////////////////////////////////////////////////////
   // Mute decision and drive shaping

   wire [3:0] muted_now;
   wire [3:0] pos_w;
   wire [3:0] neg_w;
   wire [3:0] vcm_w;
   wire [3:0] rail_w;

   // Only the auto-disable bit and source validity decide muting
   assign muted_now = auto_disable_q & {OMC_NCH{~clk_src_valid}};

   // Each decoder takes one field; ch4 in [1:0] up to ch7 in [7:6]
   for (genvar g = 0; g < OMC_NCH; g++) begin : g_ch
      omc_drive_decode u_dec (
         .level_code(upper_channel_mute_level_q[g*OMC_LVL_W +: OMC_LVL_W]),
         .differential(format_q[g]),
         .muted(muted_now[g]),
         .run_clk(chan_run_clk[g]),
         .pos_level(pos_w[g]),
         .neg_level(neg_w[g]),
         .to_vcm(vcm_w[g]),
         .pos_to_rail(rail_w[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register writes

   // Defaults left as reset; recommended code 3 is software's job
   assign upper_channel_mute_level_d = (wr_lane0 && hit_level) ? wb_dat_i[7:0]
                                                               : upper_channel_mute_level_q;
   assign auto_disable_d = (wr_lane0 && hit_auto) ? wb_dat_i[OMC_AUTO_LSB +: OMC_NCH] : auto_disable_q;
   assign format_d = (wr_lane0 && hit_format) ? wb_dat_i[OMC_FORMAT_LSB +: OMC_NCH] : format_q;

   ////////////////////////////////////////////////////////////////////////////
   // Read mux; unmapped words read zero

   logic [7:0] rd_byte;
   always_comb begin
      rd_byte = 8'h00;
      if (hit_level) begin
         rd_byte = upper_channel_mute_level_q;
      end else if (hit_auto) begin
         rd_byte[OMC_AUTO_LSB +: OMC_NCH] = auto_disable_q;
      end else if (hit_status) begin
         rd_byte[OMC_STAT_MUTED_LSB +: OMC_NCH] = chan_muted;
         rd_byte[OMC_STAT_VALID_BIT] = clk_src_valid;
      end else if (hit_format) begin
         rd_byte[OMC_FORMAT_LSB +: OMC_NCH] = format_q;
      end
   end

   assign rdata_d = take ? {24'h000000, rd_byte} : rdata_q;

   // Ack one cycle after the request; no take while in the ack state forbids a double take
   always_comb begin
      bus_d = bus_q;
      case (bus_q)
         OMC_BUS_IDLE: begin
            if (req) begin
               bus_d = OMC_BUS_ACK;
            end
         end
         OMC_BUS_ACK: begin
            bus_d = OMC_BUS_IDLE;
         end
         default: begin
            bus_d = OMC_BUS_IDLE;
         end
      endcase
   end

   assign wb_ack_o = (bus_q == OMC_BUS_ACK);
   assign wb_dat_o = rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // State

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bus_q <= OMC_BUS_IDLE;
         upper_channel_mute_level_q <= OMC_MUTE_LEVEL_RST;
         auto_disable_q <= OMC_AUTO_DISABLE_RST;
         format_q <= OMC_FORMAT_RST;
         rdata_q <= 32'h00000000;
      end else begin
         bus_q <= bus_d;
         upper_channel_mute_level_q <= upper_channel_mute_level_d;
         auto_disable_q <= auto_disable_d;
         format_q <= format_d;
         rdata_q <= rdata_d;
      end
   end

   // Drive outputs registered; one cycle behind the running clock input
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         chan_pos <= 4'h0;
         chan_neg <= 4'h0;
         chan_vcm <= 4'h0;
         chan_rail <= 4'h0;
         chan_muted <= 4'h0;
      end else begin
         chan_pos <= pos_w;
         chan_neg <= neg_w;
         chan_vcm <= vcm_w;
         chan_rail <= rail_w;
         chan_muted <= muted_now;
      end
   end

endmodule // omc_mute_level

// *** verification/omc_mute_level_properties.sv ***
`timescale 1ns/1ps
module omc_mute_level_checker (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   input wire logic clk_src_valid,
   input wire logic [3:0] chan_pos,
   input wire logic [3:0] chan_neg,
   input wire logic [3:0] chan_vcm,
   input wire logic [3:0] chan_rail,
   input wire logic [3:0] chan_muted
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////
   a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   a_ack_after_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
   a_no_stray_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
   a_upper_data_zero: assert property (wb_dat_o[31:8] == 24'h000000) else $error("upper read bits set");
   a_valid_no_mute: assert property ($past(clk_src_valid) |-> chan_muted == 4'h0) else $error("muted while valid");
   // Flags only ever belong to muted channels
   a_flags_need_mute: assert property (((chan_vcm | chan_rail) & ~chan_muted) == 4'h0) else $error("flag unmuted");
   a_rail_nodes: assert property ((chan_rail & (~chan_pos | chan_neg)) == 4'h0) else $error("rail node levels");
   a_vcm_nodes_low: assert property ((chan_vcm & (chan_pos | chan_neg | chan_rail)) == 4'h0) else $error("vcm nodes");
endmodule // omc_mute_level_checker
bind omc_mute_level omc_mute_level_checker u_chk (.*);

// *** verification/tb.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb;
   import omc_pkg::*;
   logic mclk = 1'h0, rst_n = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0, valid = 1'h1, ack;
   logic [7:0] adr = 8'h00, q;
   logic [3:0] sel = 4'h0, run = 4'hA, pos, neg, vcm, rail, muted;
   logic [31:0] dat = 32'h0, dat_o;
   int fails = 0, num_checks = 0;
   always #2 mclk = ~mclk;
   omc_mute_level dut (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .clk_src_valid(valid),
      .chan_run_clk(run), .chan_pos(pos), .chan_neg(neg), .chan_vcm(vcm), .chan_rail(rail), .chan_muted(muted));
   ////////////////////////////////////////////////////////////
   // Waits for ack with a bound; a missing ack counts as a mismatch
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
      int n;
      @(posedge mclk);
      {cyc, stb, we, adr, sel, dat} <= {2'h3, w, a, s, 24'h0, d};
      n = 0;
      do begin @(posedge mclk); n++; end while (ack !== 1'h1 && n < 50);
      if (ack !== 1'h1) fails++;
      q = dat_o[7:0];
      {cyc, stb} <= 2'h0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d); wb(1'h1, a, d, 4'h1); endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e); wb(1'h0, a, 8'h00, 4'h1); `CHK(q, e) endtask
   // Expected {pos,neg,vcm,rail} with every channel muted at one code
   function automatic logic [15:0] ex(input logic [1:0] c, input logic d, input logic [3:0] r);
      case ({d, c})
         3'h4: ex = {r, ~r, 8'h00};
         3'h5: ex = {8'h00, 4'hF, 4'h0};
         3'h6: ex = {4'hF, 12'h000};
         3'h7: ex = {4'hF, 8'h00, 4'hF};
         3'h0: ex = {r, r, 8'h00};
         3'h1: ex = {r, 12'h000};
         3'h2: ex = {4'h0, r, 8'h00};
         default: ex = 16'h0000;
      endcase
   endfunction
   task automatic conclude();
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge mclk);
      rst_n <= 1'h1;
      rd(8'h54, 8'h55);
      rd(8'h58, 8'hF0);
      rd(8'h60, 8'h0F);
      wr(8'h54, 8'hE4);
      rd(8'h54, 8'hE4);
      wb(1'h1, 8'h54, 8'h00, 4'h0);
      rd(8'h54, 8'hE4);
      rd(8'hFC, 8'h00);
      `CHK(muted, 4'h0)
      valid <= 1'h0;
      // Mixed codes 0..3 from ch4 up prove which field feeds which channel
      repeat (2) @(posedge mclk);
      `CHK({pos, neg, vcm, rail}, 16'hC128)
      for (int f = 0; f < 2; f++) for (int c = 0; c < 4; c++) begin
         wr(8'h60, f ? 8'h00 : 8'h0F);
         wr(8'h54, {4{c[1:0]}});
         repeat (2) @(posedge mclk);
         `CHK({pos, neg, vcm, rail}, ex(c[1:0], f == 0, run))
      end
      rd(8'h5C, 8'hF0);
      wr(8'h58, 8'h50);
      repeat (2) @(posedge mclk);
      `CHK(muted, 4'h5)
      valid <= 1'h1;
      run <= 4'h5;
      repeat (2) @(posedge mclk);
      `CHK({pos, neg, vcm, rail}, ex(2'h0, 1'h0, run))
      `CHK(muted, 4'h0)
      conclude();
   end
   // Whole run is about 120 cycles
   initial begin #20000; fails++; conclude(); end
endmodule // tb
